/* design/pmm_modbus_regs.sv */
// Purpose: Read-only holding-register bank answering Modbus read requests.
// Assumes: Request and response bytes are PDU bytes; framing and CRC live outside.
// Notes:   Requests arriving while a request is being served wait until its last response byte is loaded.

`timescale 1ns/1ps

module pmm_modbus_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        reqValid,
  input  wire logic        reqFirst,
  input  wire logic [7:0]  reqData,
  output logic             reqReady,
  output logic             rspValid,
  output logic [7:0]       rspData,
  output logic             rspLast,
  input  wire logic        rspReady,
  input  wire logic [31:0] temperatureValue,
  input  wire logic [31:0] dewPointValue,
  input  wire logic [31:0] humidityProbeSerialA,
  input  wire logic [31:0] humidityProbeSerialB,
  input  wire logic [31:0] humidityProbeStatus,
  input  wire logic [31:0] particles0p1To0p5,
  input  wire logic [31:0] particles0p5To1p0,
  input  wire logic [31:0] particles1p0To5p0,
  input  wire logic [31:0] particles0p3To0p5,
  input  wire logic [31:0] particleUnitSerial,
  input  wire logic [31:0] particleUnitStatus,
  input  wire logic [31:0] oilVaporValue,
  input  wire logic [31:0] linePressureValue,
  input  wire logic [31:0] oilUnitSerial,
  input  wire logic [31:0] oilUnitStatus,
  input  wire logic [31:0] unitSerial,
  input  wire logic [31:0] rackSerial,
  input  wire logic [31:0] displayStatus
);

  // ==========================================================================
  // State
  pmm_pkg::pmm_state_e state_ff;
  pmm_pkg::pmm_state_e nxt_state;
  logic [2:0]          byteIdx_ff;
  logic [2:0]          nxt_byteIdx;
  logic [7:0]          func_ff;
  logic [7:0]          nxt_func;
  logic [15:0]         start_ff;
  logic [15:0]         nxt_start;
  logic [15:0]         qty_ff;
  logic [15:0]         nxt_qty;
  logic [15:0]         curAddr_ff;
  logic [15:0]         nxt_curAddr;
  logic [15:0]         remain_ff;
  logic [15:0]         nxt_remain;
  logic                phase_ff;
  logic                nxt_phase;
  logic                firstReg_ff;
  logic                nxt_firstReg;
  logic [31:0]         hold_ff;
  logic [31:0]         nxt_hold;
  logic [7:0]          excCode_ff;
  logic [7:0]          nxt_excCode;
  logic [7:0]          rspData_ff;
  logic [7:0]          nxt_rspData;
  logic                rspValid_ff;
  logic                nxt_rspValid;
  logic                rspLast_ff;
  logic                nxt_rspLast;

  // ==========================================================================
  // Value lookup for the register now being served
  logic [31:0] selValue;
  logic        selHit;

  pmm_reg_select u_select (
    .regAddr              (curAddr_ff),
    .temperatureValue     (temperatureValue),
    .dewPointValue        (dewPointValue),
    .humidityProbeSerialA (humidityProbeSerialA),
    .humidityProbeSerialB (humidityProbeSerialB),
    .humidityProbeStatus  (humidityProbeStatus),
    .particles0p1To0p5    (particles0p1To0p5),
    .particles0p5To1p0    (particles0p5To1p0),
    .particles1p0To5p0    (particles1p0To5p0),
    .particles0p3To0p5    (particles0p3To0p5),
    .particleUnitSerial   (particleUnitSerial),
    .particleUnitStatus   (particleUnitStatus),
    .oilVaporValue        (oilVaporValue),
    .linePressureValue    (linePressureValue),
    .oilUnitSerial        (oilUnitSerial),
    .oilUnitStatus        (oilUnitStatus),
    .unitSerial           (unitSerial),
    .rackSerial           (rackSerial),
    .displayStatus        (displayStatus),
    .selValue             (selValue),
    .selHit               (selHit)
  );

  // ==========================================================================
  // Handshake and data outputs
  logic        canLoad;
  logic [2:0]  reqPos;
  logic        evenAddr;
  logic [31:0] srcValue;

  assign reqReady = (state_ff == pmm_pkg::PMM_IDLE);
  assign rspValid = rspValid_ff;
  assign rspData  = rspData_ff;
  assign rspLast  = rspLast_ff;

  // Output byte slot is free when empty or being drained this cycle
  assign canLoad  = !rspValid_ff || rspReady;
  assign reqPos   = reqFirst ? 3'h0 : byteIdx_ff;
  assign evenAddr = !curAddr_ff[0];

  // Odd register not opening the request reuses the value caught with its low half
  assign srcValue = (evenAddr || firstReg_ff) ? selValue : hold_ff;

  // ==========================================================================
  // Next-state logic of request parsing and response sequencing

  // Register walk step, shared by the range check and the data phase
  function automatic logic [15:0] addrStep(input logic [15:0] addr);
    return addr + 16'h0001;
  endfunction

  // Remaining-count step; callers stop at one, so it never wraps
  function automatic logic [15:0] countStep(input logic [15:0] cnt);
    return cnt - 16'h0001;
  endfunction

  // Every register holds its value unless a branch below moves it; valid and last drop once taken
  always_comb begin
    nxt_state    = state_ff;
    nxt_byteIdx  = byteIdx_ff;
    nxt_func     = func_ff;
    nxt_start    = start_ff;
    nxt_qty      = qty_ff;
    nxt_curAddr  = curAddr_ff;
    nxt_remain   = remain_ff;
    nxt_phase    = phase_ff;
    nxt_firstReg = firstReg_ff;
    nxt_hold     = hold_ff;
    nxt_excCode  = excCode_ff;
    nxt_rspData  = rspData_ff;
    nxt_rspValid = rspValid_ff && !rspReady;
    nxt_rspLast  = rspLast_ff && !rspReady; // Leaves with its byte
    case (state_ff)
      // Collect five bytes; a first-byte mark restarts a broken request
      pmm_pkg::PMM_IDLE: begin
        if (reqValid) begin
          case (reqPos)
            3'h0:    nxt_func         = reqData;
            3'h1:    nxt_start[15:8]  = reqData;
            3'h2:    nxt_start[7:0]   = reqData;
            3'h3:    nxt_qty[15:8]    = reqData;
            default: nxt_qty[7:0]     = reqData;
          endcase
          nxt_byteIdx = reqPos + 3'h1;
          if (reqPos == pmm_pkg::REQ_LAST_IDX) begin
            nxt_state = pmm_pkg::PMM_EVAL;
          end
        end
      end
      // Only reads exist; any write or other function is refused untouched
      pmm_pkg::PMM_EVAL: begin
        nxt_byteIdx = 3'h0;
        if (func_ff != pmm_pkg::FUNC_READ_HOLD) begin
          nxt_excCode = pmm_pkg::EXC_ILLEGAL_FUNC;
          nxt_state   = pmm_pkg::PMM_EXC_FUNC;
        end else if (qty_ff == 16'h0000 || qty_ff > pmm_pkg::MAX_QTY) begin
          nxt_excCode = pmm_pkg::EXC_ILLEGAL_VALUE;
          nxt_state   = pmm_pkg::PMM_EXC_FUNC;
        end else begin
          nxt_curAddr = start_ff;
          nxt_remain  = qty_ff;
          nxt_state   = pmm_pkg::PMM_CHECK;
        end
      end
      // Walk the whole range first so a gap refuses the request before any data
      pmm_pkg::PMM_CHECK: begin
        if (!selHit) begin
          nxt_excCode = pmm_pkg::EXC_ILLEGAL_ADDR;
          nxt_state   = pmm_pkg::PMM_EXC_FUNC;
        end else if (remain_ff == 16'h0001) begin
          nxt_curAddr  = start_ff;
          nxt_remain   = qty_ff;
          nxt_phase    = 1'b0;
          nxt_firstReg = 1'b1;
          nxt_state    = pmm_pkg::PMM_HDR_FUNC;
        end else begin
          nxt_curAddr = addrStep(curAddr_ff);
          nxt_remain  = countStep(remain_ff);
        end
      end
      // Response opens with the read function code
      pmm_pkg::PMM_HDR_FUNC: begin
        if (canLoad) begin
          nxt_rspData  = pmm_pkg::FUNC_READ_HOLD;
          nxt_rspValid = 1'b1;
          nxt_rspLast  = 1'b0;
          nxt_state    = pmm_pkg::PMM_HDR_CNT;
        end
      end
      // Byte count is two per register; quantity is capped at 125 so it fits
      pmm_pkg::PMM_HDR_CNT: begin
        if (canLoad) begin
          nxt_rspData  = {qty_ff[6:0], 1'b0};
          nxt_rspValid = 1'b1;
          nxt_rspLast  = 1'b0;
          nxt_state    = pmm_pkg::PMM_DATA;
        end
      end
      // Low word carries bytes 1,0 and high word bytes 3,2
      pmm_pkg::PMM_DATA: begin
        if (canLoad) begin
          nxt_rspValid = 1'b1;
          nxt_rspLast  = 1'b0;
          if (!phase_ff) begin
            nxt_rspData = evenAddr ? srcValue[15:8] : srcValue[31:24];
            nxt_hold    = srcValue;
            nxt_phase   = 1'b1;
          end else begin
            nxt_rspData = evenAddr ? hold_ff[7:0] : hold_ff[23:16];
            nxt_phase   = 1'b0;
            if (remain_ff == 16'h0001) begin
              nxt_rspLast = 1'b1;
              nxt_state   = pmm_pkg::PMM_IDLE;
            end else begin
              nxt_curAddr  = addrStep(curAddr_ff);
              nxt_remain   = countStep(remain_ff);
              nxt_firstReg = 1'b0;
            end
          end
        end
      end
      // Exception answer echoes the function with its top bit set
      pmm_pkg::PMM_EXC_FUNC: begin
        if (canLoad) begin
          nxt_rspData  = func_ff | pmm_pkg::EXC_FLAG;
          nxt_rspValid = 1'b1;
          nxt_rspLast  = 1'b0;
          nxt_state    = pmm_pkg::PMM_EXC_CODE;
        end
      end
      pmm_pkg::PMM_EXC_CODE: begin
        if (canLoad) begin
          nxt_rspData  = excCode_ff;
          nxt_rspValid = 1'b1;
          nxt_rspLast  = 1'b1;
          nxt_state    = pmm_pkg::PMM_IDLE;
        end
      end
      default: begin
        nxt_state = pmm_pkg::PMM_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Registers, synchronous active-low reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff    <= pmm_pkg::PMM_IDLE;
      byteIdx_ff  <= 3'h0;
      func_ff     <= 8'h00;
      start_ff    <= 16'h0000;
      qty_ff      <= 16'h0000;
      curAddr_ff  <= 16'h0000;
      remain_ff   <= 16'h0000;
      phase_ff    <= 1'b0;
      firstReg_ff <= 1'b0;
      hold_ff     <= pmm_pkg::HOLD_RST;
      excCode_ff  <= 8'h00;
      rspData_ff  <= pmm_pkg::RSP_DATA_RST;
      rspValid_ff <= 1'b0;
      rspLast_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      byteIdx_ff  <= nxt_byteIdx;
      func_ff     <= nxt_func;
      start_ff    <= nxt_start;
      qty_ff      <= nxt_qty;
      curAddr_ff  <= nxt_curAddr;
      remain_ff   <= nxt_remain;
      phase_ff    <= nxt_phase;
      firstReg_ff <= nxt_firstReg;
      hold_ff     <= nxt_hold;
      excCode_ff  <= nxt_excCode;
      rspData_ff  <= nxt_rspData;
      rspValid_ff <= nxt_rspValid;
      rspLast_ff  <= nxt_rspLast;
    end
  end

endmodule // pmm_modbus_regs

/* design/pmm_pkg.sv */
// Purpose: Shared constants and types of the purity monitor holding-register bank.
// Assumes: Requests arrive as Modbus PDU bytes from framing logic on the same clock.
// Notes:   Holding-register addresses are register numbers, one 16-bit word each.

package pmm_pkg;

  // ==========================================================================
  // Protocol codes
  localparam logic [7:0]  FUNC_READ_HOLD    = 8'h03;
  localparam logic [7:0]  EXC_FLAG          = 8'h80;
  localparam logic [7:0]  EXC_ILLEGAL_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] MAX_QTY           = 16'h007D;
  localparam logic [2:0]  REQ_LAST_IDX      = 3'h4;

  // ==========================================================================
  // Holding-register start addresses, each the low word of a 32-bit value
  localparam logic [15:0] ADDR_TEMPERATURE    = 16'h0002;
  localparam logic [15:0] ADDR_DEW_POINT      = 16'h0004;
  localparam logic [15:0] ADDR_HUM_SERIAL_A   = 16'h000A;
  localparam logic [15:0] ADDR_HUM_SERIAL_B   = 16'h000C;
  localparam logic [15:0] ADDR_HUM_STATUS     = 16'h000E;
  localparam logic [15:0] ADDR_PART_0P1_0P5   = 16'h0014;
  localparam logic [15:0] ADDR_PART_0P5_1P0   = 16'h0016;
  localparam logic [15:0] ADDR_PART_1P0_5P0   = 16'h0018;
  localparam logic [15:0] ADDR_PART_0P3_0P5   = 16'h001A;
  localparam logic [15:0] ADDR_PART_SERIAL    = 16'h001E;
  localparam logic [15:0] ADDR_PART_STATUS    = 16'h0020;
  localparam logic [15:0] ADDR_OIL_VAPOR      = 16'h0028;
  localparam logic [15:0] ADDR_LINE_PRESSURE  = 16'h002A;
  localparam logic [15:0] ADDR_OIL_SERIAL     = 16'h0030;
  localparam logic [15:0] ADDR_OIL_STATUS     = 16'h0032;
  localparam logic [15:0] ADDR_DISPLAY_SERIAL = 16'h003C;
  localparam logic [15:0] ADDR_RACK_SERIAL    = 16'h003E;
  localparam logic [15:0] ADDR_DISPLAY_STATUS = 16'h0040;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RSP_DATA_RST = 8'h00;
  localparam logic [31:0] HOLD_RST     = 32'h0000_0000;

  // ==========================================================================
  // Request and response sequencer states
  typedef enum logic [2:0] {
    PMM_IDLE,
    PMM_EVAL,
    PMM_CHECK,
    PMM_HDR_FUNC,
    PMM_HDR_CNT,
    PMM_DATA,
    PMM_EXC_FUNC,
    PMM_EXC_CODE
  } pmm_state_e;

endpackage

/* design/pmm_reg_select.sv */
// Purpose: Maps a holding-register address onto the 32-bit value it belongs to.
// Assumes: Value inputs are steady for at least one cycle around each lookup.
// Notes:   Pure decode; both words of a pair select the same value.

`timescale 1ns/1ps

module pmm_reg_select (
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] temperatureValue,
  input  wire logic [31:0] dewPointValue,
  input  wire logic [31:0] humidityProbeSerialA,
  input  wire logic [31:0] humidityProbeSerialB,
  input  wire logic [31:0] humidityProbeStatus,
  input  wire logic [31:0] particles0p1To0p5,
  input  wire logic [31:0] particles0p5To1p0,
  input  wire logic [31:0] particles1p0To5p0,
  input  wire logic [31:0] particles0p3To0p5,
  input  wire logic [31:0] particleUnitSerial,
  input  wire logic [31:0] particleUnitStatus,
  input  wire logic [31:0] oilVaporValue,
  input  wire logic [31:0] linePressureValue,
  input  wire logic [31:0] oilUnitSerial,
  input  wire logic [31:0] oilUnitStatus,
  input  wire logic [31:0] unitSerial,
  input  wire logic [31:0] rackSerial,
  input  wire logic [31:0] displayStatus,
  output logic      [31:0] selValue,
  output logic             selHit
);

  // ==========================================================================
  // Decode on the even base address of the pair
  logic [15:0] baseAddr;

  assign baseAddr = {regAddr[15:1], 1'b0};

  // Unknown addresses return zero and no hit, so the caller raises an exception
  always_comb begin
    selHit   = 1'b1;
    selValue = 32'h0000_0000;
    case (baseAddr)
      pmm_pkg::ADDR_TEMPERATURE:    selValue = temperatureValue;
      pmm_pkg::ADDR_DEW_POINT:      selValue = dewPointValue;
      pmm_pkg::ADDR_HUM_SERIAL_A:   selValue = humidityProbeSerialA;
      pmm_pkg::ADDR_HUM_SERIAL_B:   selValue = humidityProbeSerialB;
      pmm_pkg::ADDR_HUM_STATUS:     selValue = humidityProbeStatus;
      pmm_pkg::ADDR_PART_0P1_0P5:   selValue = particles0p1To0p5;
      pmm_pkg::ADDR_PART_0P5_1P0:   selValue = particles0p5To1p0;
      pmm_pkg::ADDR_PART_1P0_5P0:   selValue = particles1p0To5p0;
      pmm_pkg::ADDR_PART_0P3_0P5:   selValue = particles0p3To0p5;
      pmm_pkg::ADDR_PART_SERIAL:    selValue = particleUnitSerial;
      pmm_pkg::ADDR_PART_STATUS:    selValue = particleUnitStatus;
      pmm_pkg::ADDR_OIL_VAPOR:      selValue = oilVaporValue;
      pmm_pkg::ADDR_LINE_PRESSURE:  selValue = linePressureValue;
      pmm_pkg::ADDR_OIL_SERIAL:     selValue = oilUnitSerial;
      pmm_pkg::ADDR_OIL_STATUS:     selValue = oilUnitStatus;
      pmm_pkg::ADDR_DISPLAY_SERIAL: selValue = unitSerial;
      pmm_pkg::ADDR_RACK_SERIAL:    selValue = rackSerial;
      pmm_pkg::ADDR_DISPLAY_STATUS: selValue = displayStatus;
      default:                      selHit   = 1'b0;
    endcase
  end

endmodule // pmm_reg_select

/* tb/pmm_master_model.sv */
// Purpose: Polling master that sends request PDUs of any function code and sinks responses.
// Assumes: Bank samples request bytes on the rising edge.
// Notes:   Host views of the last four bytes are offered for both orders.
`timescale 1ns/1ps

module pmm_master_model (
  input  wire logic        clk,
  input  wire logic        reqReady,
  input  wire logic        rspValid,
  input  wire logic [7:0]  rspData,
  input  wire logic        stallOn,
  output logic             reqValid,
  output logic             reqFirst,
  output logic [7:0]       reqData,
  output logic             rspReady,
  output logic [31:0]      hostBe,
  output logic [31:0]      hostLe
);
  logic [31:0] rx_ff;

  initial begin
    reqValid = 1'b0;
    reqFirst = 1'b0;
    reqData  = 8'h00;
  end

  // Random stalls, so the bank must hold each byte while unaccepted
  always @(negedge clk) rspReady <= stallOn ? ($urandom_range(3) != 0) : 1'b1;

  // Keep the last four accepted bytes, oldest on top
  always @(posedge clk) if (rspValid && rspReady) rx_ff <= {rx_ff[23:0], rspData};

  // Host reordering of a 1-0-3-2 value
  assign hostBe = {rx_ff[15:0], rx_ff[31:16]};
  assign hostLe = {rx_ff[23:16], rx_ff[31:24], rx_ff[7:0], rx_ff[15:8]};

  // Whole request in one go, so both halves come from one value
  task automatic sendReq(input logic [7:0] fn, input logic [15:0] start,
                         input logic [15:0] qty, output bit stuck);
    logic [7:0] b [5];
    int         n;
    b = '{fn, start[15:8], start[7:0], qty[15:8], qty[7:0]};
    stuck = 1'b0;
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      reqValid = 1'b1;
      reqFirst = (i == 0);
      reqData  = b[i];
      n = 0;
      while (reqReady !== 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      if (n >= 400) stuck = 1'b1;
      @(posedge clk);
    end
    @(negedge clk);
    reqValid = 1'b0;
    reqFirst = 1'b0;
  endtask
endmodule // pmm_master_model

/* tb/pmm_regs_monitor.sv */
// Purpose: Port-level protocol checks for the holding-register bank.
// Assumes: One clock domain; nrst synchronous, active low.
// Notes:   Helpers follow request fields and the response byte index.
`timescale 1ns/1ps

module pmm_regs_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reqValid,
  input wire logic       reqFirst,
  input wire logic [7:0] reqData,
  input wire logic       reqReady,
  input wire logic       rspValid,
  input wire logic [7:0] rspData,
  input wire logic       rspLast,
  input wire logic       rspReady
);
  // ====================
  // Helpers
  logic [2:0]  pos_ff;
  logic [2:0]  curPos;
  logic [7:0]  func_ff;
  logic [7:0]  qtyHi_ff;
  logic [15:0] qty_ff;
  logic [7:0]  rCnt_ff;
  logic [7:0]  head_ff;
  logic [7:0]  rFunc_ff;
  logic [15:0] rQty_ff;
  logic        take;
  logic        acc;

  assign take   = reqValid && reqReady;
  assign acc    = rspValid && rspReady;
  assign curPos = reqFirst ? 3'h0 : pos_ff;

  // Only bytes really taken count, so refused bytes cannot skew fields
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pos_ff  <= 3'h0;
      rCnt_ff <= 8'h00;
    end else begin
      if (take) begin
        pos_ff <= curPos + 3'h1;
        if (curPos == 3'h0) func_ff <= reqData;
        if (curPos == 3'h3) qtyHi_ff <= reqData;
        if (curPos == 3'h4) qty_ff <= {qtyHi_ff, reqData};
      end
      if (acc) rCnt_ff <= rspLast ? 8'h00 : rCnt_ff + 8'h01;
      // Snapshot the request behind this response; a new one may land under its last byte
      if (acc && rCnt_ff == 8'h00) begin
        head_ff  <= rspData;
        rFunc_ff <= func_ff;
        rQty_ff  <= qty_ff;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ====================
  // Properties
  sequence s_excTake;
    take && curPos == 3'h4 && func_ff != pmm_pkg::FUNC_READ_HOLD && !rspValid;
  endsequence
  sequence s_excAns;
    rspValid && rspData == (func_ff | pmm_pkg::EXC_FLAG);
  endsequence

  property p_rstIdle;
    disable iff (1'b0) !nrst |=> reqReady && !rspValid && !rspLast
      && rspData == pmm_pkg::RSP_DATA_RST;
  endproperty
  property p_stallHold;
    rspValid && !rspReady |=> rspValid && $stable(rspData) && $stable(rspLast);
  endproperty
  property p_lastValid;
    rspLast |-> rspValid;
  endproperty
  property p_busyNoReq;
    rspValid && !rspLast |-> !reqReady;
  endproperty
  property p_headCode;
    rspValid && rCnt_ff == 8'h00 |-> rspData == func_ff
      || rspData == (func_ff | pmm_pkg::EXC_FLAG);
  endproperty
  property p_excFunc;
    rspValid && rCnt_ff == 8'h01 && rFunc_ff != pmm_pkg::FUNC_READ_HOLD
      |-> rspData == pmm_pkg::EXC_ILLEGAL_FUNC && rspLast;
  endproperty
  property p_qtyExc;
    rspValid && rCnt_ff == 8'h01 && rFunc_ff == pmm_pkg::FUNC_READ_HOLD
      && (rQty_ff == 16'h0000 || rQty_ff > pmm_pkg::MAX_QTY)
      |-> rspData == pmm_pkg::EXC_ILLEGAL_VALUE && rspLast;
  endproperty
  property p_byteCnt;
    rspValid && rCnt_ff == 8'h01 && head_ff == pmm_pkg::FUNC_READ_HOLD
      |-> rspData == {rQty_ff[6:0], 1'b0} && !rspLast;
  endproperty
  property p_rspLen;
    rspLast && rCnt_ff != 8'h00 && head_ff == pmm_pkg::FUNC_READ_HOLD
      |-> rCnt_ff == {rQty_ff[6:0], 1'b0} + 8'h01;
  endproperty
  property p_excLat;
    s_excTake |-> ##[2:4] s_excAns;
  endproperty

  a_rstIdle: assert property (p_rstIdle) else $error("response not idle after reset");
  a_stallHold: assert property (p_stallHold) else $error("byte changed under stall");
  a_lastValid: assert property (p_lastValid) else $error("last without valid");
  a_busyNoReq: assert property (p_busyNoReq) else $error("ready during response");
  a_headCode: assert property (p_headCode) else $error("bad function byte");
  a_excFunc: assert property (p_excFunc) else $error("bad function exception");
  a_qtyExc: assert property (p_qtyExc) else $error("bad quantity exception");
  a_byteCnt: assert property (p_byteCnt) else $error("bad byte count");
  a_rspLen: assert property (p_rspLen) else $error("bad response length");
  a_excLat: assert property (p_excLat) else $error("exception late");
endmodule // pmm_regs_monitor

bind pmm_modbus_regs pmm_regs_monitor u_mon (
  .clk(clk), .nrst(nrst), .reqValid(reqValid), .reqFirst(reqFirst),
  .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
  .rspData(rspData), .rspLast(rspLast), .rspReady(rspReady)
);

/* tb/tb_purity_monitor_modbus_register_map.sv */
// Purpose: Self-checking bench for the holding-register bank.
// Assumes: Values stay steady while a response is pending.
// Notes:   Expected bytes are queued by the driver and popped by a watcher.
`timescale 1ns/1ps

module tb_purity_monitor_modbus_register_map;
  localparam logic [15:0] ADR [18] = '{16'h0002, 16'h0004, 16'h000A, 16'h000C,
    16'h000E, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001E, 16'h0020,
    16'h0028, 16'h002A, 16'h0030, 16'h0032, 16'h003C, 16'h003E, 16'h0040};
  localparam logic [7:0] FN [4] = '{8'h06, 8'h10, 8'h01, 8'h04};
  logic        clk, nrst, stallOn, reqValid, reqFirst, reqReady;
  logic        rspValid, rspLast, rspReady;
  logic [7:0]  reqData, rspData;
  logic [31:0] vals [18];
  logic [31:0] hostBe, hostLe;
  logic [8:0]  expQ [$];
  int          errors, num_checks;

  // ====================
  // Clock and instances
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  pmm_modbus_regs dut (
    .clk(clk), .nrst(nrst), .reqValid(reqValid), .reqFirst(reqFirst),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .rspLast(rspLast), .rspReady(rspReady),
    .temperatureValue(vals[0]), .dewPointValue(vals[1]),
    .humidityProbeSerialA(vals[2]), .humidityProbeSerialB(vals[3]),
    .humidityProbeStatus(vals[4]), .particles0p1To0p5(vals[5]),
    .particles0p5To1p0(vals[6]), .particles1p0To5p0(vals[7]),
    .particles0p3To0p5(vals[8]), .particleUnitSerial(vals[9]),
    .particleUnitStatus(vals[10]), .oilVaporValue(vals[11]),
    .linePressureValue(vals[12]), .oilUnitSerial(vals[13]),
    .oilUnitStatus(vals[14]), .unitSerial(vals[15]),
    .rackSerial(vals[16]), .displayStatus(vals[17])
  );

  pmm_master_model m (
    .clk(clk), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .stallOn(stallOn), .reqValid(reqValid), .reqFirst(reqFirst),
    .reqData(reqData), .rspReady(rspReady), .hostBe(hostBe), .hostLe(hostLe)
  );

  // ====================
  // Checking helpers
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk9(input string what, input logic [8:0] e, input logic [8:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  task chk32(input string what, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  function logic [31:0] valAt(input logic [15:0] a);
    valAt = 32'h0000_0000;
    for (int i = 0; i < 18; i++) if (ADR[i] == {a[15:1], 1'b0}) valAt = vals[i];
  endfunction

  task push(input logic l, input logic [7:0] d);
    expQ.push_back({l, d});
  endtask

  task req(input logic [7:0] fn, input logic [15:0] start, input logic [15:0] qty);
    bit s;
    m.sendReq(fn, start, qty, s);
    if (s) begin
      errors++;
      $display("unexpected stall of request bytes");
      print_verdict();
    end
  endtask

  // Even register gives the low half, odd one the high half
  task rd(input logic [15:0] start, input logic [15:0] qty);
    logic [31:0] v;
    logic [15:0] r;
    push(1'b0, pmm_pkg::FUNC_READ_HOLD);
    push(1'b0, {qty[6:0], 1'b0});
    for (int i = 0; i < qty; i++) begin
      r = start + i[15:0];
      v = valAt(r);
      if (r[0]) begin
        push(1'b0, v[31:24]);
        push(i == qty - 1, v[23:16]);
      end else begin
        push(1'b0, v[15:8]);
        push(i == qty - 1, v[7:0]);
      end
    end
    req(pmm_pkg::FUNC_READ_HOLD, start, qty);
  endtask

  task ex(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] q,
          input logic [7:0] code);
    push(1'b0, fn | pmm_pkg::EXC_FLAG);
    push(1'b1, code);
    req(fn, st, q);
  endtask

  task drain;
    int n;
    n = 0;
    while ((expQ.size() != 0 || rspValid !== 1'b0) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("unexpected response still pending");
      print_verdict();
    end
  endtask

  // Watcher: every accepted byte is matched against the oldest note
  always @(posedge clk) begin
    if (nrst && rspValid === 1'b1 && rspReady === 1'b1) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("unexpected response byte seen %h", rspData);
      end else chk9("rsp", expQ.pop_front(), {rspLast, rspData});
    end
  end

  // ====================
  // Main sequence
  initial begin
    void'($urandom(32'h23B2));
    nrst = 1'b0;
    stallOn = 1'b0;
    errors = 0;
    num_checks = 0;
    foreach (vals[i]) vals[i] = $urandom();
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    // Each channel as one pair, then reordered by the host
    for (int i = 0; i < 18; i++) begin
      rd(ADR[i], 16'h0002);
      drain();
      chk32("host be", vals[i], hostBe);
      chk32("host le", {vals[i][7:0], vals[i][15:8], vals[i][23:16],
            vals[i][31:24]}, hostLe);
      vals[i] = $urandom();
    end
    // Back to back under stalls
    stallOn = 1'b1;
    rd(16'h0002, 16'h0004);
    rd(16'h003C, 16'h0006);
    rd(16'h0003, 16'h0001);
    rd(16'h0014, 16'h0008);
    for (int i = 0; i < 4; i++) ex(FN[i], 16'h0002, 16'h0002, pmm_pkg::EXC_ILLEGAL_FUNC);
    ex(8'h03, 16'h0002, 16'h0000, pmm_pkg::EXC_ILLEGAL_VALUE);
    ex(8'h03, 16'h0002, 16'h007E, pmm_pkg::EXC_ILLEGAL_VALUE);
    ex(8'h03, 16'h0002, 16'h007D, pmm_pkg::EXC_ILLEGAL_ADDR);
    ex(8'h03, 16'h0000, 16'h0002, pmm_pkg::EXC_ILLEGAL_ADDR);
    ex(8'h03, 16'h0006, 16'h0002, pmm_pkg::EXC_ILLEGAL_ADDR);
    ex(8'h03, 16'h0040, 16'h0003, pmm_pkg::EXC_ILLEGAL_ADDR);
    rd(16'h0002, 16'h0002);
    drain();
    print_verdict();
  end
endmodule // tb_purity_monitor_modbus_register_map
